// ---- fsi_frequent_start.sv ----
/*
  Frequent start inhibit: start stress accumulator, interval guard,
  mode handling and Avalon-MM register slave.
  Assumes motor current and thermal level arrive as asynchronous pin
  levels from the measurement and thermal overload functions.
*/
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module fsi_frequent_start
  import fsi_pkg::*;
#(
  parameter int ACC_W    = 40,
  parameter int TICK_CYC = FSI_TENTH_CYCLES
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // Avalon-MM slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Measurements
  input  wire logic [7:0]  i_motor_current,
  input  wire logic [9:0]  i_thermal_theta,
  input  wire logic        i_thermal_enabled,
  input  wire logic        i_allow_logical_node_mode,
  // Outputs
  output logic             o_motor_start_detect,
  output logic             o_alarm,
  output logic             o_restart_inhibit,
  output logic [1:0]       o_condition
);
  initial begin
    if (ACC_W < 32 || ACC_W > 48 || TICK_CYC < 1) begin
      $error("fsi_frequent_start: unsupported parameter");
    end
  end

  // ==========================================================
  // Synchronised inputs
  logic [19:0] sync_in;
  logic [7:0]  cur_s;
  logic [9:0]  theta_s;
  logic        th_en_s;
  logic        allow_s;

  fsi_sync #(.W(20)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_allow_logical_node_mode, i_thermal_enabled,
                 i_thermal_theta, i_motor_current}),
    .o_sync    (sync_in)
  );
  assign cur_s   = sync_in[7:0];
  assign theta_s = sync_in[17:8];
  assign th_en_s = sync_in[18];
  assign allow_s = sync_in[19];

  // ==========================================================
  // Settings
  logic [2:0]  logical_node_mode_q;
  logic [13:0] stall_cold_q;
  logic [13:0] stall_hot_q;
  logic [6:0]  starts_cold_q;
  logic [6:0]  starts_hot_q;
  logic [6:0]  hours_q;
  logic [13:0] mingap_q;
  logic [9:0]  theta_lim_q;
  logic [7:0]  ist_q;
  logic [7:0]  run_lvl_q;
  logic        wr_en;

  // Mode is outside any setting group, so only a bus write changes it
  assign wr_en = i_avs_write && o_avs_waitrequest;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      logical_node_mode_q     <= FSI_MODE_ON; // RULE13
      stall_cold_q  <= FSI_RST_STALL_COLD;
      stall_hot_q   <= FSI_RST_STALL_HOT;
      starts_cold_q <= FSI_RST_STARTS_C;
      starts_hot_q  <= FSI_RST_STARTS_H;
      hours_q       <= FSI_RST_HOURS;
      mingap_q      <= FSI_RST_MINGAP;
      theta_lim_q   <= FSI_RST_THETA_LIM;
      ist_q         <= FSI_RST_IST;
      run_lvl_q     <= FSI_RST_MOTOR_ON;
    end else if (wr_en) begin
      unique case (i_avs_address)
        FSI_REG_CTRL: begin
          if (allow_s && i_avs_writedata[2:0] >= FSI_MODE_ON &&
              i_avs_writedata[2:0] <= FSI_MODE_OFF) begin
            logical_node_mode_q <= i_avs_writedata[2:0]; // RULE14 RULE17
          end
          theta_lim_q <= i_avs_writedata[17:8];
        end
        FSI_REG_STALL: begin
          stall_cold_q <= i_avs_writedata[13:0];
          stall_hot_q  <= i_avs_writedata[29:16];
        end
        FSI_REG_STARTS: begin
          if (i_avs_writedata[6:0] != 7'h00) begin
            starts_cold_q <= i_avs_writedata[6:0]; // RULE18
          end
          if (i_avs_writedata[14:8] != 7'h00) begin
            starts_hot_q <= i_avs_writedata[14:8];
          end
          if (i_avs_writedata[22:16] != 7'h00) begin
            hours_q <= i_avs_writedata[22:16];
          end
        end
        FSI_REG_MINGAP: begin
          if (i_avs_writedata[13:0] != 14'h0000) begin
            mingap_q <= i_avs_writedata[13:0]; // RULE19
          end
        end
        FSI_REG_CURRENT: begin
          ist_q     <= i_avs_writedata[7:0];
          run_lvl_q <= i_avs_writedata[15:8];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Program cycle tick, one per 0.1 s
  logic [31:0] tick_cnt_q;
  logic        tick_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // ==========================================================
  // Motor start detection from current rising through run level
  logic running_q;
  logic start_pulse;
  assign start_pulse = (cur_s >= run_lvl_q) && !running_q; // RULE12
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      running_q            <= 1'b0;
      o_motor_start_detect <= 1'b0;
    end else begin
      running_q            <= cur_s >= run_lvl_q;
      o_motor_start_detect <= start_pulse;
    end
  end

  // ==========================================================
  // Hot/cold choice
  logic        hot;
  logic [13:0] stall_sel;
  logic [6:0]  starts_sel;
  // Without thermal supervision every start is treated as cold
  assign hot = th_en_s && (theta_s > theta_lim_q); // RULE11 RULE10
  assign stall_sel  = hot ? stall_hot_q : stall_cold_q;
  assign starts_sel = hot ? starts_hot_q : starts_cold_q;

  // ==========================================================
  // Start stress accumulator
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] unit;
  logic [ACC_W-1:0] limit;
  logic [ACC_W-1:0] decay;
  logic [ACC_W-1:0] ttl_tenths;
  logic [ACC_W-1:0] acc_gap;

  assign unit  = ACC_W'(stall_sel) * ACC_W'(ist_q); // RULE4 RULE1
  assign limit = unit * ACC_W'(starts_sel);
  // Per 0.1 s the decay is one start per window divided into tenths
  assign decay = (unit + ACC_W'(FSI_TENTHS_PER_H) * ACC_W'(hours_q)
                  - ACC_W'(1)) /
                 (ACC_W'(FSI_TENTHS_PER_H) * ACC_W'(hours_q)); // RULE2
  assign acc_gap = (acc_q + unit > limit) ? acc_q + unit - limit : '0;
  assign ttl_tenths = (decay == '0) ? '0 : acc_gap / decay;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      acc_q <= '0;
    end else if (start_pulse) begin
      acc_q <= acc_q + unit; // RULE1
    end else if (tick_q) begin
      // RULE9 RULE3: decay uses the rate of the present thermal state
      acc_q <= (acc_q > decay) ? acc_q - decay : '0;
    end
  end

  // ==========================================================
  // Minimum interval guard
  logic [13:0] gap_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      gap_q <= '0;
    end else if (start_pulse) begin
      gap_q <= mingap_q; // RULE7
    end else if (tick_q && gap_q != 14'h0000) begin
      gap_q <= gap_q - 14'h0001;
    end
  end

  // ==========================================================
  // Counts and decisions
  logic [6:0] used;
  logic [6:0] avail;
  logic       exhausted;
  logic       one_left;
  logic       suppress;
  logic [ACC_W-1:0] used_full;

  assign used_full = (unit == '0) ? '0 : (acc_q + unit - 1) / unit;
  assign used  = (used_full > ACC_W'(starts_sel)) ? starts_sel
                 : used_full[6:0];
  assign avail = starts_sel - used; // RULE8
  assign exhausted = acc_q + unit > limit; // RULE6 RULE9
  assign one_left  = avail == 7'h01; // RULE5
  assign suppress  = logical_node_mode_q == FSI_MODE_BLOCKED ||
                     logical_node_mode_q == FSI_MODE_TESTBLK ||
                     logical_node_mode_q == FSI_MODE_OFF; // RULE20

  logic [13:0] inh_time_q;
  logic [13:0] alm_time_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_alarm           <= 1'b0;
      o_restart_inhibit <= 1'b0;
      o_condition       <= FSI_COND_NORMAL;
      inh_time_q        <= '0;
      alm_time_q        <= '0;
    end else begin
      o_alarm           <= one_left && !suppress; // RULE5 RULE20
      o_restart_inhibit <= (exhausted || gap_q != 14'h0000) &&
                           !suppress; // RULE6 RULE7
      inh_time_q <= (gap_q > ttl_tenths[13:0] || ttl_tenths > 14'h3fff)
                    ? (ttl_tenths > 14'h3fff ? 14'h3fff : gap_q)
                    : ttl_tenths[13:0]; // RULE8
      alm_time_q <= one_left ? ttl_tenths[13:0] : '0;
      // RULE16
      // A pending alarm or inhibit held back by the mode reads as blocked
      if ((exhausted || gap_q != 14'h0000 || one_left) && suppress) begin
        o_condition <= FSI_COND_BLOCKED;
      end else if (exhausted || gap_q != 14'h0000) begin
        o_condition <= FSI_COND_TRIP;
      end else if (one_left) begin
        o_condition <= FSI_COND_START;
      end else begin
        o_condition <= FSI_COND_NORMAL;
      end
    end
  end

  // ==========================================================
  // Avalon-MM: one wait cycle, answer on the second edge
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && o_avs_waitrequest) begin
      unique case (i_avs_address)
        // RULE15 RULE17: mode fields read zero when not allowed
        FSI_REG_CTRL:    o_avs_readdata <= {14'h0, theta_lim_q, 1'b0,
                           allow_s ? logical_node_mode_q : 3'h0,
                           1'b0, allow_s ? logical_node_mode_q : 3'h0};
        FSI_REG_STALL:   o_avs_readdata <= {2'h0, stall_hot_q,
                                            2'h0, stall_cold_q};
        FSI_REG_STARTS:  o_avs_readdata <= {9'h0, hours_q, 1'b0,
                                            starts_hot_q, 1'b0,
                                            starts_cold_q};
        FSI_REG_MINGAP:  o_avs_readdata <= {18'h0, mingap_q};
        FSI_REG_CURRENT: o_avs_readdata <= {16'h0, run_lvl_q, ist_q};
        FSI_REG_STATUS:  o_avs_readdata <= {25'h0, hot, o_restart_inhibit,
                                            o_alarm, 2'h0, o_condition};
        FSI_REG_COUNTS:  o_avs_readdata <= {17'h0, avail, 1'b0, used};
        FSI_REG_INHTIME: o_avs_readdata <= {18'h0, inh_time_q};
        FSI_REG_ALMTIME: o_avs_readdata <= {18'h0, alm_time_q};
        FSI_REG_ACCUM:   o_avs_readdata <= acc_q[31:0];
        default:         o_avs_readdata <= '0;
      endcase
    end
  end
endmodule // fsi_frequent_start
`default_nettype wire

// ---- fsi_pkg.sv ----
/*
  Package for the frequent start inhibit block: register map, field codes,
  reset values and timing constants shared by the design files.
  Assumes a 50 MHz system clock and an Avalon-MM slave with 32-bit data.
*/
// Behaviour
// RULE1: Each start adds safe stall time stress.
// RULE2: Decay equals stall time over window hours.
// RULE3: Counter decays once every program cycle.
// RULE4: Increment is stall time times start current.
// RULE5: Alarm when exactly one start remains.
// RULE6: Inhibit after last start until decayed.
// RULE7: Inhibit if starts closer than minimum interval.
// RULE8: Report inhibit time, alarm, used, available starts.
// RULE9: Hot and exhausted: inhibit, decay at hot rate.
// RULE10: Stopped and below hot limit: cold rate.
// RULE11: Hot/cold split only with thermal function enabled.
// RULE12: Motor start detected internally from current.
// RULE13: Mode codes On..Off are 1..5, default On.
// RULE14: Mode setting is static, unaffected by groups.
// RULE15: Read-only behaviour reports active mode.
// RULE16: Condition: Normal 0, Start 1, Trip 2, Blocked 3.
// RULE17: Mode access only when individual modes allowed.
// RULE18: Separate cold and hot start counts per window.
// RULE19: Minimum interval in 0.1 s steps, default 20.0 s.
// RULE20: Blocked, Test/Blocked, Off suppress alarm and inhibit.
package fsi_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [5:0] FSI_REG_CTRL    = 6'h00;
  localparam logic [5:0] FSI_REG_STALL   = 6'h04;
  localparam logic [5:0] FSI_REG_STARTS  = 6'h08;
  localparam logic [5:0] FSI_REG_MINGAP  = 6'h0c;
  localparam logic [5:0] FSI_REG_CURRENT = 6'h10;
  localparam logic [5:0] FSI_REG_STATUS  = 6'h14;
  localparam logic [5:0] FSI_REG_COUNTS  = 6'h18;
  localparam logic [5:0] FSI_REG_INHTIME = 6'h1c;
  localparam logic [5:0] FSI_REG_ALMTIME = 6'h20;
  localparam logic [5:0] FSI_REG_ACCUM   = 6'h24;

  // ==========================================================
  // Codes
  localparam logic [2:0] FSI_MODE_ON      = 3'h1;
  localparam logic [2:0] FSI_MODE_BLOCKED = 3'h2;
  localparam logic [2:0] FSI_MODE_TEST    = 3'h3;
  localparam logic [2:0] FSI_MODE_TESTBLK = 3'h4;
  localparam logic [2:0] FSI_MODE_OFF     = 3'h5;
  localparam logic [1:0] FSI_COND_NORMAL  = 2'h0;
  localparam logic [1:0] FSI_COND_START   = 2'h1;
  localparam logic [1:0] FSI_COND_TRIP    = 2'h2;
  localparam logic [1:0] FSI_COND_BLOCKED = 2'h3;

  // ==========================================================
  // Reset values (times in 0.1 s, theta in 0.1 %)
  localparam logic [13:0] FSI_RST_STALL_COLD = 14'h00c8; // 20.0 s
  localparam logic [13:0] FSI_RST_STALL_HOT  = 14'h0096; // 15.0 s
  localparam logic [6:0]  FSI_RST_STARTS_C   = 7'h03;
  localparam logic [6:0]  FSI_RST_STARTS_H   = 7'h02;
  localparam logic [6:0]  FSI_RST_HOURS      = 7'h01;
  localparam logic [13:0] FSI_RST_MINGAP     = 14'h00c8; // 20.0 s
  localparam logic [9:0]  FSI_RST_THETA_LIM  = 10'h2bc;  // 70.0 %
  localparam logic [7:0]  FSI_RST_IST        = 8'h0a;    // start current
  localparam logic [7:0]  FSI_RST_MOTOR_ON   = 8'h01;    // running level

  // ==========================================================
  // Timing
  localparam int FSI_CLK_HZ       = 50_000_000;
  localparam int FSI_TENTH_S_NS   = 100_000_000;
  localparam int FSI_CLK_NS       = 1_000_000_000 / FSI_CLK_HZ;
  localparam int FSI_TENTH_CYCLES = FSI_TENTH_S_NS / FSI_CLK_NS;
  localparam int FSI_TENTHS_PER_H = 36_000;

endpackage : fsi_pkg

// ---- fsi_sync.sv ----
/*
  Three-stage input synchroniser with agreement filter.
  Assumes the input is asynchronous to i_sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module fsi_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_sys_rst,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      o_sync <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once stages two and three agree
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          o_sync[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // fsi_sync
`default_nettype wire

// ---- fsi_frequent_start_checker.sv ----
/*
  Checker for the frequent start inhibit block: bus handshake, start
  pulse and condition code relations, bound to the top module's ports.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module fsi_frequent_start_checker
  import fsi_pkg::*;
(
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  // Bus
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // Outputs
  input wire logic        o_motor_start_detect,
  input wire logic        o_alarm,
  input wire logic        o_restart_inhibit,
  input wire logic [1:0]  o_condition
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence

  sequence s_ans;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  // ==========================================================
  // Assertions
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus request not answered in one cycle");
  a_no_idle_ans: assert property (
    !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest dropped without a request");
  a_rd_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");
  a_start_pulse: assert property (
    o_motor_start_detect |=> !o_motor_start_detect)
    else $error("start detect longer than one cycle");
  a_cond_trip: assert property (
    o_restart_inhibit |-> o_condition == FSI_COND_TRIP)
    else $error("inhibit without trip condition");
  a_cond_alarm: assert property (
    o_alarm && !o_restart_inhibit |-> o_condition == FSI_COND_START)
    else $error("alarm without start condition");
  a_cond_block: assert property (
    o_condition == FSI_COND_BLOCKED |-> !o_alarm && !o_restart_inhibit)
    else $error("outputs active while blocked");
  a_reset_quiet: assert property (disable iff (1'b0)
    i_sys_rst |=> !o_alarm && !o_restart_inhibit && o_avs_waitrequest)
    else $error("outputs active after reset");
endmodule // fsi_frequent_start_checker
`default_nettype wire

// ---- tb_frequent_start_inhibit.sv ----
/*
  Self-checking testbench for the frequent start inhibit block.
  Assumes a shortened program cycle (TICK_CYC) and binds the checker.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_frequent_start_inhibit;
  import fsi_pkg::*;
  localparam int TICK = 10;

  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [5:0]  adr   = 6'h00;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wdat  = 32'h0;
  logic [7:0]  cur   = 8'h00;
  logic [9:0]  theta = 10'h000;
  logic        th_en = 1'b0;
  logic        allow = 1'b1;
  logic [31:0] rdat;
  logic        wreq;
  logic        msd;
  logic        alarm;
  logic        inh;
  logic [1:0]  cond;
  logic [31:0] rv;
  int          n_fail = 0;
  int          checks_done = 0;

  fsi_frequent_start #(.TICK_CYC(TICK)) dut_u (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_motor_current(cur), .i_thermal_theta(theta),
    .i_thermal_enabled(th_en), .i_allow_logical_node_mode(allow),
    .o_motor_start_detect(msd), .o_alarm(alarm),
    .o_restart_inhibit(inh), .o_condition(cond));

  initial forever #10 clk = ~clk;

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Mismatches %0d, checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    rv = rdat;
    chk({31'h0, wreq}, 32'h0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask

  task automatic start_motor;
    int i;
    @(posedge clk);
    cur <= 8'h01;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (msd === 1'b1) break;
    end
    chk({31'h0, msd}, 32'h1);
    repeat (5) @(posedge clk);
    cur <= 8'h00;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_inh(input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(negedge clk);
      if (inh === v) break;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk({28'h0, alarm, inh, cond}, 32'h0);
    rd_chk(FSI_REG_STALL, 32'hffffffff, 32'h009600c8);
    rd_chk(FSI_REG_STARTS, 32'hffffffff, 32'h00010203);
    rd_chk(FSI_REG_MINGAP, 32'hffffffff, 32'h000000c8);
    rd_chk(FSI_REG_CURRENT, 32'h0000ffff, 32'h0000010a);
    rd_chk(FSI_REG_COUNTS, 32'h00007f7f, 32'h00000300);
    rd_chk(FSI_REG_CTRL, 32'h0003ff70, 32'h0002bc10);
    rd_chk(6'h3c, 32'hffffffff, 32'h0);
  endtask

  task automatic t_mode;
    logic [2:0] m;
    for (m = 3'h1; m <= 3'h5; m++) begin
      bus(1'b1, FSI_REG_CTRL, {24'h0002bc, 5'h0, m});
      rd_chk(FSI_REG_CTRL, 32'h70, {25'h0, m, 4'h0});
      repeat (3) @(negedge clk);
      chk(cond, 2'h0);
    end
    bus(1'b1, FSI_REG_CTRL, 32'h0002bc00);
    rd_chk(FSI_REG_CTRL, 32'h70, 32'h50);
    allow <= 1'b0;
    repeat (10) @(posedge clk);
    bus(1'b1, FSI_REG_CTRL, 32'h0002bc01);
    rd_chk(FSI_REG_CTRL, 32'h70, 32'h0);
    allow <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk(FSI_REG_CTRL, 32'h70, 32'h50);
    bus(1'b1, FSI_REG_CTRL, 32'h0002bc01);
  endtask

  task automatic t_starts;
    bus(1'b1, FSI_REG_CURRENT, 32'h00000101);
    bus(1'b1, FSI_REG_MINGAP, 32'd50);
    start_motor();
    chk({alarm, inh}, 2'b01);
    start_motor();
    chk(inh, 1'b1);
    chk(cond, FSI_COND_TRIP);
    wait_inh(1'b0, 700);
    chk(inh, 1'b0);
    chk(alarm, 1'b1);
    chk(cond, FSI_COND_START);
    bus(1'b1, FSI_REG_CTRL, 32'h0002bc02);
    repeat (3) @(negedge clk);
    chk({alarm, cond}, 3'b011);
    bus(1'b1, FSI_REG_CTRL, 32'h0002bc01);
    repeat (3) @(negedge clk);
    chk(alarm, 1'b1);
    bus(1'b1, FSI_REG_MINGAP, 32'd1);
    start_motor();
    chk(inh, 1'b1);
    repeat (500) @(negedge clk);
    chk(inh, 1'b1);
    wait_inh(1'b0, 3000);
    chk(inh, 1'b0);
  endtask

  // Cold counter near two starts is exhausted under the hot allowance
  task automatic t_hot;
    @(posedge clk);
    theta <= 10'h3ff;
    th_en <= 1'b1;
    repeat (10) @(negedge clk);
    rd_chk(FSI_REG_STATUS, 32'h40, 32'h40);
    chk(inh, 1'b1);
    @(posedge clk);
    th_en <= 1'b0;
    repeat (10) @(negedge clk);
    chk(inh, 1'b0);
    rd_chk(FSI_REG_STATUS, 32'h40, 32'h0);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge clk);
    t_reset();
    t_mode();
    t_starts();
    t_hot();
    complete_run();
  end

  initial begin
    #400_000;
    n_fail++;
    complete_run();
  end
endmodule // tb_frequent_start_inhibit

bind fsi_frequent_start fsi_frequent_start_checker chk_u (
  .i_sys_clk, .i_sys_rst, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .o_motor_start_detect, .o_alarm,
  .o_restart_inhibit, .o_condition);
`default_nettype wire
